// File: logic/agmc_map.svh
// register offsets, reset values, field positions and write masks of the config slice
`ifndef AGMC_MAP_SVH
`define AGMC_MAP_SVH

// ==========================================
// offsets
`define AGMC_OFS_PAGE      8'h00
`define AGMC_OFS_EDGE      8'h19
`define AGMC_OFS_GATE_CFG  8'h6B
`define AGMC_OFS_TH_HIGH   8'h6C
`define AGMC_OFS_TH_MID    8'h6D
`define AGMC_OFS_TH_LOW    8'h6E
`define AGMC_OFS_HOLD_HIGH 8'h6F
`define AGMC_OFS_HOLD_LOW  8'h70
`define AGMC_OFS_UVLO      8'h71
`define AGMC_OFS_DAC       8'h73
`define AGMC_OFS_CKSUM     8'h7E
`define AGMC_OFS_BOOK      8'h7F

// ==========================================
// books and pages holding this slice
`define AGMC_BOOK_MAIN 8'h00
`define AGMC_PAGE_MAIN 8'h00
`define AGMC_PAGE_EDGE 8'h01

// ==========================================
// reset values
`define AGMC_RST_PAGE      8'h00
`define AGMC_RST_EDGE      8'h40
`define AGMC_RST_GATE_CFG  8'h43
`define AGMC_RST_TH_HIGH   8'h00
`define AGMC_RST_TH_MID    8'h00
`define AGMC_RST_TH_LOW    8'h1A
`define AGMC_RST_HOLD_HIGH 8'h00
`define AGMC_RST_HOLD_LOW  8'h96
`define AGMC_RST_UVLO      8'h02
`define AGMC_RST_DAC       8'h00
`define AGMC_RST_CKSUM     8'h00
`define AGMC_RST_BOOK      8'h00

// ==========================================
// field positions and writable bits
`define AGMC_BIT_BATT_CONV 6
`define AGMC_BIT_FINE_EN   2
`define AGMC_BIT_DEM_HI    7
`define AGMC_BIT_DEM_LO    6
`define AGMC_BIT_DITH_OFF  5
`define AGMC_BIT_LIN_EDGE  6
`define AGMC_UVLO_HI       5
`define AGMC_HOLD_DROP     3
`define AGMC_WMASK_GATE    8'h7F
`define AGMC_WMASK_DAC     8'hE0
`define AGMC_WMASK_EDGE    8'h40

`endif

// File: logic/agmc_pkg.sv
// types shared by the config slice modules
`default_nettype none
package agmc_pkg;

   typedef logic [7:0] agmc_byte_t;

   // element matching selection, in code order 0..3
   typedef enum logic [1:0] {
      AGMC_DEM_BOTH_ON,
      AGMC_DEM_MSB_ONLY,
      AGMC_DEM_LSB_ONLY,
      AGMC_DEM_BOTH_OFF
   } agmc_dem_e;

endpackage
`default_nettype wire

// File: logic/agmc_wr_checksum.sv
// running checksum over host writes
`timescale 1ns/1ps
`default_nettype none
`include "agmc_map.svh"

module agmc_wr_checksum
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic wr_i,
   input wire logic ck_hit_i,
   input wire agmc_pkg::agmc_byte_t addr_i,
   input wire agmc_pkg::agmc_byte_t data_i,
   output var agmc_pkg::agmc_byte_t sum_o
);
   import agmc_pkg::*;

   agmc_byte_t sum;
   agmc_byte_t next_sum;

   // ==========================================
   // accumulation
   // modulo-256 sum of address plus data; cheap, but blind to swapped writes
   always_comb
   begin
      next_sum = sum;
      if (wr_i && ck_hit_i)
      begin
         next_sum = data_i;
      end
      else if (wr_i)
      begin
         next_sum = agmc_byte_t'(sum + addr_i + data_i);
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         sum <= `AGMC_RST_CKSUM;
      else
         sum <= next_sum;
   end

   assign sum_o = sum;

   // ==========================================
   // checks
   a_cksum_load_value: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      wr_i && ck_hit_i |=> sum == $past(data_i))
      else $error("checksum not loaded by write");

   a_cksum_accum_step: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      wr_i && !ck_hit_i |=> sum == agmc_byte_t'($past(sum) + $past(addr_i) + $past(data_i)))
      else $error("checksum not accumulated");

   a_cksum_idle_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !wr_i |=> $stable(sum))
      else $error("checksum moved without a write");

endmodule
`default_nettype wire

// File: logic/agmc_read_mux.sv
// registered read data selection
`timescale 1ns/1ps
`default_nettype none
`include "agmc_map.svh"

module agmc_read_mux
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic rd_i,
   input wire logic main_sel_i,
   input wire logic edge_sel_i,
   input wire agmc_pkg::agmc_byte_t addr_i,
   input wire agmc_pkg::agmc_byte_t page_i,
   input wire agmc_pkg::agmc_byte_t book_i,
   input wire agmc_pkg::agmc_byte_t cksum_i,
   input wire agmc_pkg::agmc_byte_t gate_cfg_i,
   input wire agmc_pkg::agmc_byte_t th_high_i,
   input wire agmc_pkg::agmc_byte_t th_mid_i,
   input wire agmc_pkg::agmc_byte_t th_low_i,
   input wire agmc_pkg::agmc_byte_t hold_high_i,
   input wire agmc_pkg::agmc_byte_t hold_low_i,
   input wire agmc_pkg::agmc_byte_t uvlo_i,
   input wire agmc_pkg::agmc_byte_t dac_ctrl_i,
   input wire agmc_pkg::agmc_byte_t edge_i,
   output var agmc_pkg::agmc_byte_t rdata_o,
   output logic rvalid_o
);
   import agmc_pkg::*;

   agmc_byte_t rdata;
   agmc_byte_t next_rdata;
   logic rvalid;
   logic next_rvalid;

   // ==========================================
   // selection; unmapped addresses read as zero
   always_comb
   begin
      next_rvalid = rd_i;
      next_rdata = rdata;
      if (rd_i)
      begin
         next_rdata = 8'h00;
         if (addr_i == `AGMC_OFS_PAGE)
            next_rdata = page_i;
         else if (addr_i == `AGMC_OFS_CKSUM)
            next_rdata = cksum_i;
         else if (addr_i == `AGMC_OFS_BOOK)
            next_rdata = book_i;
         else if (edge_sel_i && addr_i == `AGMC_OFS_EDGE)
            next_rdata = edge_i;
         else if (main_sel_i)
         begin
            unique case (addr_i)
               `AGMC_OFS_GATE_CFG: next_rdata = gate_cfg_i;
               `AGMC_OFS_TH_HIGH: next_rdata = th_high_i;
               `AGMC_OFS_TH_MID: next_rdata = th_mid_i;
               `AGMC_OFS_TH_LOW: next_rdata = th_low_i;
               `AGMC_OFS_HOLD_HIGH: next_rdata = hold_high_i;
               `AGMC_OFS_HOLD_LOW: next_rdata = hold_low_i;
               `AGMC_OFS_UVLO: next_rdata = uvlo_i;
               `AGMC_OFS_DAC: next_rdata = dac_ctrl_i;
               default: next_rdata = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rdata <= 8'h00;
         rvalid <= 1'b0;
      end
      else
      begin
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   assign rdata_o = rdata;
   assign rvalid_o = rvalid;

   // ==========================================
   // checks
   a_read_cksum_value: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == `AGMC_OFS_CKSUM |=> rvalid && rdata == $past(cksum_i))
      else $error("checksum read returned wrong value");

endmodule
`default_nettype wire

// File: logic/agmc_cfg_regs.sv
// noise gate, undervoltage, dac matching, checksum and book configuration registers
//
// Function
// - battery conversion when brownout sourced from supply
// - gate config bit 2 enables fine mode
// - fine threshold assembled from three bytes
// - threshold resets to 1Ah, minus 110 dBFS
// - hold count bits 18:3 in two bytes
// - six-bit field selects undervoltage trip level
// - bits 7:6 select dac matching enables
// - bit 5 set disables msb modulator dither
// - checksum register reads back, write loads it
// - every other write updates the checksum
// - book register selects books 0 to 255
`timescale 1ns/1ps
`default_nettype none
`include "agmc_map.svh"

module agmc_cfg_regs
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire agmc_pkg::agmc_byte_t reg_addr_i,
   input wire agmc_pkg::agmc_byte_t reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic brownout_guard_src_supply_i,
   output var agmc_pkg::agmc_byte_t reg_rdata_o,
   output logic reg_rvalid_o,
   output var agmc_pkg::agmc_byte_t book_o,
   output var agmc_pkg::agmc_byte_t page_o,
   output logic battery_sense_convert_o,
   output logic gate_fine_mode_enable_o,
   output logic [23:0] gate_fine_threshold_o,
   output logic [18:0] gate_fine_hold_count_o,
   output logic [5:0] power_undervoltage_threshold_o,
   output var agmc_pkg::agmc_dem_e dac_element_matching_ctrl_o,
   output logic dac_msb_match_en_o,
   output logic dac_lsb_match_en_o,
   output logic modulator_dither_off_o,
   output logic linear_edge_select_o
);
   import agmc_pkg::*;

   // ==========================================
   // register state
   agmc_byte_t page;
   agmc_byte_t book;
   agmc_byte_t gate_cfg;
   agmc_byte_t th_high;
   agmc_byte_t th_mid;
   agmc_byte_t th_low;
   agmc_byte_t hold_high;
   agmc_byte_t hold_low;
   agmc_byte_t uvlo;
   agmc_byte_t dac_ctrl;
   agmc_byte_t edge_mod;
   agmc_byte_t next_page;
   agmc_byte_t next_book;
   agmc_byte_t next_gate_cfg;
   agmc_byte_t next_th_high;
   agmc_byte_t next_th_mid;
   agmc_byte_t next_th_low;
   agmc_byte_t next_hold_high;
   agmc_byte_t next_hold_low;
   agmc_byte_t next_uvlo;
   agmc_byte_t next_dac_ctrl;
   agmc_byte_t next_edge_mod;
   agmc_byte_t cksum;
   logic main_sel;
   logic edge_sel;
   logic ck_hit;

   // the slice lives in book 0; page and book registers answer everywhere
   assign main_sel = (book == `AGMC_BOOK_MAIN) && (page == `AGMC_PAGE_MAIN);
   assign edge_sel = (book == `AGMC_BOOK_MAIN) && (page == `AGMC_PAGE_EDGE);
   assign ck_hit = (reg_addr_i == `AGMC_OFS_CKSUM);

   // ==========================================
   // write decode
   // read-only bits keep their reset value whatever the host writes
   always_comb
   begin
      next_page = page;
      next_book = book;
      next_gate_cfg = gate_cfg;
      next_th_high = th_high;
      next_th_mid = th_mid;
      next_th_low = th_low;
      next_hold_high = hold_high;
      next_hold_low = hold_low;
      next_uvlo = uvlo;
      next_dac_ctrl = dac_ctrl;
      next_edge_mod = edge_mod;
      if (reg_wr_i)
      begin
         if (reg_addr_i == `AGMC_OFS_PAGE)
            next_page = reg_wdata_i;
         else if (reg_addr_i == `AGMC_OFS_BOOK)
            next_book = reg_wdata_i;
         else if (edge_sel && reg_addr_i == `AGMC_OFS_EDGE)
            next_edge_mod = (reg_wdata_i & `AGMC_WMASK_EDGE)
                          | (`AGMC_RST_EDGE & ~`AGMC_WMASK_EDGE);
         else if (main_sel)
         begin
            unique case (reg_addr_i)
               `AGMC_OFS_GATE_CFG: next_gate_cfg = (reg_wdata_i & `AGMC_WMASK_GATE)
                                                 | (`AGMC_RST_GATE_CFG & ~`AGMC_WMASK_GATE);
               `AGMC_OFS_TH_HIGH: next_th_high = reg_wdata_i;
               `AGMC_OFS_TH_MID: next_th_mid = reg_wdata_i;
               `AGMC_OFS_TH_LOW: next_th_low = reg_wdata_i;
               `AGMC_OFS_HOLD_HIGH: next_hold_high = reg_wdata_i;
               `AGMC_OFS_HOLD_LOW: next_hold_low = reg_wdata_i;
               `AGMC_OFS_UVLO: next_uvlo = reg_wdata_i;
               `AGMC_OFS_DAC: next_dac_ctrl = (reg_wdata_i & `AGMC_WMASK_DAC)
                                            | (`AGMC_RST_DAC & ~`AGMC_WMASK_DAC);
               default: next_page = page;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         page <= `AGMC_RST_PAGE;
         book <= `AGMC_RST_BOOK;
         gate_cfg <= `AGMC_RST_GATE_CFG;
         th_high <= `AGMC_RST_TH_HIGH;
         th_mid <= `AGMC_RST_TH_MID;
         th_low <= `AGMC_RST_TH_LOW;
         hold_high <= `AGMC_RST_HOLD_HIGH;
         hold_low <= `AGMC_RST_HOLD_LOW;
         uvlo <= `AGMC_RST_UVLO;
         dac_ctrl <= `AGMC_RST_DAC;
         edge_mod <= `AGMC_RST_EDGE;
      end
      else
      begin
         page <= next_page;
         book <= next_book;
         gate_cfg <= next_gate_cfg;
         th_high <= next_th_high;
         th_mid <= next_th_mid;
         th_low <= next_th_low;
         hold_high <= next_hold_high;
         hold_low <= next_hold_low;
         uvlo <= next_uvlo;
         dac_ctrl <= next_dac_ctrl;
         edge_mod <= next_edge_mod;
      end
   end

   // ==========================================
   // checksum and read path
   agmc_wr_checksum u_cksum
   (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .wr_i(reg_wr_i),
      .ck_hit_i(ck_hit),
      .addr_i(reg_addr_i),
      .data_i(reg_wdata_i),
      .sum_o(cksum)
   );

   agmc_read_mux u_rd
   (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .rd_i(reg_rd_i),
      .main_sel_i(main_sel),
      .edge_sel_i(edge_sel),
      .addr_i(reg_addr_i),
      .page_i(page),
      .book_i(book),
      .cksum_i(cksum),
      .gate_cfg_i(gate_cfg),
      .th_high_i(th_high),
      .th_mid_i(th_mid),
      .th_low_i(th_low),
      .hold_high_i(hold_high),
      .hold_low_i(hold_low),
      .uvlo_i(uvlo),
      .dac_ctrl_i(dac_ctrl),
      .edge_i(edge_mod),
      .rdata_o(reg_rdata_o),
      .rvalid_o(reg_rvalid_o)
   );

   // ==========================================
   // control outputs
   // computed from the next register values so a setting shows one edge after its write
   logic next_batt_conv;
   logic next_msb_en;
   logic next_lsb_en;
   agmc_dem_e next_dem;
   logic batt_conv;
   logic msb_en;
   logic lsb_en;
   agmc_dem_e dem;

   always_comb
   begin
      // the source select is a level from logic on this clock, so no synchroniser
      next_batt_conv = brownout_guard_src_supply_i
                     & next_gate_cfg[`AGMC_BIT_BATT_CONV];
      next_dem = agmc_dem_e'(next_dac_ctrl[`AGMC_BIT_DEM_HI:`AGMC_BIT_DEM_LO]);
      next_msb_en = !next_dac_ctrl[`AGMC_BIT_DEM_HI];
      next_lsb_en = !next_dac_ctrl[`AGMC_BIT_DEM_LO];
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         batt_conv <= 1'b0;
         dem <= AGMC_DEM_BOTH_ON;
         msb_en <= 1'b1;
         lsb_en <= 1'b1;
      end
      else
      begin
         batt_conv <= next_batt_conv;
         dem <= next_dem;
         msb_en <= next_msb_en;
         lsb_en <= next_lsb_en;
      end
   end

   assign book_o = book;
   assign page_o = page;
   assign battery_sense_convert_o = batt_conv;
   assign gate_fine_mode_enable_o = gate_cfg[`AGMC_BIT_FINE_EN];
   assign gate_fine_threshold_o = {th_high, th_mid, th_low};
   // low hold bits are not stored; hold resolution is eight samples
   assign gate_fine_hold_count_o = {hold_high, hold_low, 3'b000};
   assign power_undervoltage_threshold_o = uvlo[`AGMC_UVLO_HI:0];
   assign dac_element_matching_ctrl_o = dem;
   assign dac_msb_match_en_o = msb_en;
   assign dac_lsb_match_en_o = lsb_en;
   assign modulator_dither_off_o = dac_ctrl[`AGMC_BIT_DITH_OFF];
   assign linear_edge_select_o = edge_mod[`AGMC_BIT_LIN_EDGE];

   // ==========================================
   // checks
   a_batt_conv_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !gate_cfg[`AGMC_BIT_BATT_CONV] && !(reg_wr_i && main_sel)
      |=> !battery_sense_convert_o)
      else $error("battery conversion without its enable");

   a_fine_mode_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_wr_i && main_sel && reg_addr_i == `AGMC_OFS_GATE_CFG
      |=> gate_fine_mode_enable_o == $past(reg_wdata_i[`AGMC_BIT_FINE_EN]))
      else $error("fine gate mode does not follow write");

   a_threshold_mid_byte: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_wr_i && main_sel && reg_addr_i == `AGMC_OFS_TH_MID
      |=> gate_fine_threshold_o[15:8] == $past(reg_wdata_i)
          && gate_fine_threshold_o[23:16] == $past(gate_fine_threshold_o[23:16]))
      else $error("threshold middle byte misplaced");

   a_threshold_reset_code: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $past(sys_rst_i) |-> gate_fine_threshold_o == 24'h00_001A)
      else $error("threshold reset code wrong");

   a_hold_low_byte: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_wr_i && main_sel && reg_addr_i == `AGMC_OFS_HOLD_LOW
      |=> gate_fine_hold_count_o[10:3] == $past(reg_wdata_i)
          && gate_fine_hold_count_o[2:0] == 3'b000)
      else $error("hold count low byte misplaced");

   a_uvlo_field: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_wr_i && main_sel && reg_addr_i == `AGMC_OFS_UVLO
      |=> power_undervoltage_threshold_o == $past(reg_wdata_i[5:0]))
      else $error("undervoltage field does not follow write");

   a_dem_both_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_wr_i && main_sel && reg_addr_i == `AGMC_OFS_DAC && reg_wdata_i[7:6] == 2'b11
      |=> !dac_msb_match_en_o && !dac_lsb_match_en_o
          && dac_element_matching_ctrl_o == AGMC_DEM_BOTH_OFF)
      else $error("matching not fully off for code 3");

   a_dem_msb_only: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      dac_element_matching_ctrl_o == AGMC_DEM_MSB_ONLY
      |-> dac_msb_match_en_o && !dac_lsb_match_en_o)
      else $error("matching enables disagree with code 1");

   a_dither_ctrl: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_wr_i && main_sel && reg_addr_i == `AGMC_OFS_DAC
      |=> modulator_dither_off_o == $past(reg_wdata_i[`AGMC_BIT_DITH_OFF]))
      else $error("dither control does not follow write");

   a_book_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_addr_i == `AGMC_OFS_BOOK |=> book_o == $past(reg_wdata_i))
      else $error("book register does not follow write");

endmodule
`default_nettype wire

// File: test/agmc_host_model.sv
// host-side model that issues single-byte register writes and reads
`timescale 1ns/1ps
`default_nettype none

module agmc_host_model
(
   input wire logic ref_clk_i,
   output var agmc_pkg::agmc_byte_t reg_addr_o,
   output var agmc_pkg::agmc_byte_t reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o
);
   import agmc_pkg::*;

   // ==========================================
   // requests
   initial
   begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end

   // one byte per strobe, held across the taking edge
   // any undervoltage code is legal here, bridge mode is never entered
   task automatic put(input agmc_byte_t a, input agmc_byte_t d);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      reg_rd_o = 1'b0;
      @(posedge ref_clk_i);
      #1;
   endtask

   task automatic get(input agmc_byte_t a);
      reg_addr_o = a;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b1;
      @(posedge ref_clk_i);
      #1;
   endtask

   // released bus shows the inverse, so stale values cannot pass
   task automatic idle();
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = ~reg_addr_o;
      reg_wdata_o = ~reg_wdata_o;
      @(posedge ref_clk_i);
      #1;
   endtask

endmodule

`default_nettype wire

// File: test/agmc_cfg_regs_tb_top.sv
// self-checking bench for the configuration register slice
`timescale 1ns/1ps
`default_nettype none
`include "agmc_map.svh"

module agmc_cfg_regs_tb_top;
   import agmc_pkg::*;

   // ==========================================
   // signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic src = 1'b0;
   agmc_byte_t addr, wdata, rdata, book, page, cks, lfsr;
   logic wr, rd, rvalid, conv, fine_en, msb_en, lsb_en, dith, lin_edge;
   logic [23:0] thr;
   logic [18:0] hold;
   logic [5:0] uvlo;
   agmc_dem_e dem;
   int err_total = 0;
   int n_compared = 0;
   agmc_byte_t exp_q[$];
   agmc_byte_t ev[8];
   agmc_byte_t ofs[10] = '{`AGMC_OFS_GATE_CFG, `AGMC_OFS_TH_HIGH, `AGMC_OFS_TH_MID,
      `AGMC_OFS_TH_LOW, `AGMC_OFS_HOLD_HIGH, `AGMC_OFS_HOLD_LOW, `AGMC_OFS_UVLO,
      `AGMC_OFS_DAC, `AGMC_OFS_CKSUM, `AGMC_OFS_BOOK};
   agmc_byte_t rsv[10] = '{8'h43, 8'h00, 8'h00, 8'h1A, 8'h00, 8'h96, 8'h02, 8'h00,
      8'h00, 8'h00};
   agmc_byte_t msk[8] = '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hE0};

   always #10 clk = ~clk;

   agmc_host_model u_agmc_host_model (.ref_clk_i(clk), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

   agmc_cfg_regs u_agmc_cfg_regs (.ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .brownout_guard_src_supply_i(src),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .book_o(book), .page_o(page),
      .battery_sense_convert_o(conv), .gate_fine_mode_enable_o(fine_en),
      .gate_fine_threshold_o(thr), .gate_fine_hold_count_o(hold),
      .power_undervoltage_threshold_o(uvlo), .dac_element_matching_ctrl_o(dem),
      .dac_msb_match_en_o(msb_en), .dac_lsb_match_en_o(lsb_en),
      .modulator_dither_off_o(dith), .linear_edge_select_o(lin_edge));

   // ==========================================
   // helpers
   function automatic agmc_byte_t lfsr_next(input agmc_byte_t s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      if (err_total == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // checksum model: modulo-256 sum of address and data, own offset loads
   task automatic wr_b(input agmc_byte_t a, input agmc_byte_t d);
      u_agmc_host_model.put(a, d);
      cks = (a == `AGMC_OFS_CKSUM) ? d : cks + a + d;
   endtask

   task automatic rd_b(input agmc_byte_t a, input agmc_byte_t e);
      exp_q.push_back(e);
      u_agmc_host_model.get(a);
   endtask

   task automatic chk_rst();
      check("book", book, 8'h00);
      check("page", page, 8'h00);
      check("battery convert", conv, 1'b0);
      check("fine mode", fine_en, 1'b0);
      check("threshold", thr, 24'h00_001A);
      check("hold", hold, 19'h0_04B0);
      check("uvlo", uvlo, 6'h02);
      check("dem", dem, AGMC_DEM_BOTH_ON);
      check("msb match", msb_en, 1'b1);
      check("lsb match", lsb_en, 1'b1);
      check("dither off", dith, 1'b0);
      check("linear edge", lin_edge, 1'b1);
      for (int i = 0; i < 10; i++)
         rd_b(ofs[i], rsv[i]);
      u_agmc_host_model.idle();
   endtask

   // ==========================================
   // read monitor: one note per valid pulse, sampled mid-cycle
   always @(negedge clk)
   begin
      if (rvalid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("unrequested read", 1'b1, 1'b0);
         else
            check("read data", rdata, exp_q.pop_front());
      end
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      err_total++;
      print_verdict();
   end

   // ==========================================
   // main sequence
   initial
   begin
      cks = 8'h00;
      lfsr = 8'h2A;
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      chk_rst();
      // random bytes to every page-0 field, written back to back
      for (int r = 0; r < 3; r++)
      begin
         for (int i = 0; i < 8; i++)
         begin
            lfsr = lfsr_next(lfsr);
            ev[i] = (i == 4) ? (lfsr | 8'h01) : lfsr; // hold above 1 ms at 96 kHz
            wr_b(ofs[i], ev[i]);
            ev[i] = ev[i] & msk[i];
         end
         u_agmc_host_model.idle();
         for (int i = 0; i < 8; i++)
            rd_b(ofs[i], ev[i]);
         rd_b(`AGMC_OFS_CKSUM, cks);
         u_agmc_host_model.idle();
         check("fine mode", fine_en, ev[0][2]);
         check("threshold", thr, {ev[1], ev[2], ev[3]});
         check("hold", hold, {ev[4], ev[5], 3'b000});
         check("uvlo", uvlo, ev[6][5:0]);
         check("dither off", dith, ev[7][5]);
      end
      // every matching code, with refused low bits
      for (int c = 0; c < 4; c++)
      begin
         wr_b(`AGMC_OFS_DAC, {c[1:0], 6'h3F});
         u_agmc_host_model.idle();
         check("dem", dem, c[1:0]);
         check("msb match", msb_en, !c[1]);
         check("lsb match", lsb_en, !c[0]);
         check("dither off", dith, 1'b1);
         rd_b(`AGMC_OFS_DAC, {c[1:0], 6'h20});
      end
      // conversion only when supply-sourced and bit 6 set
      for (int k = 0; k < 4; k++)
      begin
         wr_b(`AGMC_OFS_GATE_CFG, k[1] ? 8'hC4 : 8'h80);
         src = k[0];
         u_agmc_host_model.idle();
         u_agmc_host_model.idle();
         check("battery convert", conv, k[0] & k[1]);
         check("fine mode", fine_en, k[1]);
      end
      rd_b(`AGMC_OFS_GATE_CFG, 8'h44);
      // checksum load, then other books and pages
      wr_b(`AGMC_OFS_CKSUM, 8'hA5);
      rd_b(`AGMC_OFS_CKSUM, 8'hA5);
      wr_b(`AGMC_OFS_TH_HIGH, 8'h12);
      wr_b(`AGMC_OFS_BOOK, 8'hFF);
      wr_b(`AGMC_OFS_TH_HIGH, 8'h77);
      rd_b(`AGMC_OFS_BOOK, 8'hFF);
      rd_b(`AGMC_OFS_CKSUM, cks);
      u_agmc_host_model.idle();
      check("book", book, 8'hFF);
      wr_b(`AGMC_OFS_BOOK, 8'h00);
      wr_b(`AGMC_OFS_PAGE, 8'h01);
      wr_b(`AGMC_OFS_TH_HIGH, 8'h55);
      wr_b(`AGMC_OFS_EDGE, 8'h80);
      u_agmc_host_model.idle();
      check("linear edge", lin_edge, 1'b0);
      wr_b(`AGMC_OFS_EDGE, 8'hFF);
      rd_b(`AGMC_OFS_EDGE, 8'h40);
      wr_b(`AGMC_OFS_PAGE, 8'h00);
      rd_b(`AGMC_OFS_TH_HIGH, 8'h12);
      rd_b(8'h50, 8'h00);
      rd_b(`AGMC_OFS_CKSUM, cks);
      u_agmc_host_model.idle();
      check("threshold high", thr[23:16], 8'h12);
      check("linear edge", lin_edge, 1'b1);
      // reset in mid-run returns every field to its reset value
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      cks = 8'h00;
      src = 1'b0;
      chk_rst();
      for (int w = 0; w < 10 && exp_q.size() != 0; w++)
         @(posedge clk);
      if (exp_q.size() != 0)
         check("pending reads", exp_q.size(), 0);
      print_verdict();
   end

endmodule

`default_nettype wire
